// [design/prog_cfg.svh]
// Constants for the test entry and programming pin decoder
`ifndef PROG_CFG_SVH
`define PROG_CFG_SVH
`define ADDR_W 16
`define DATA_W 8
`define SIG_COUNT 4
`define SIG_IDX_W 2
`define ENC_LAST_ADDR 16'h003f
`define SEL_BIT_P26 4
`define SEL_BIT_P27 3
`define SEL_BIT_P33 2
`define SEL_BIT_P36 1
`define SEL_BIT_P37 0
`define SEL_PROG_CODE 5'h0f
`define SEL_PROG_ENC 5'h0d
`define SEL_LOCK1 5'h1f
`define SEL_LOCK2 5'h1c
`define SEL_LOCK3 5'h16
`define SEL_VERIFY 5'h03
`define SEL_SIG 5'h00
`define SEL_MASK_READ 5'h17
`define SEL_MASK_ALL 5'h1f
`define SIG_BYTE0 8'h5a
`define SIG_BYTE1 8'ha5
`define SIG_BYTE2 8'h3c
`define SIG_BYTE3 8'hc3
`define PU_EMU_MASK 4'he
`define LOCK_W 3
`endif

// [design/prog_pkg.sv]
// Types for the test entry and programming pin decoder
package prog_pkg;
  typedef enum logic [2:0] {
    OP_IDLE, OP_PROG_CODE, OP_VERIFY, OP_PROG_ENC, OP_SIG_READ, OP_LOCK1, OP_LOCK2, OP_LOCK3
  } op_t;

  // Port pins as sampled from the package
  typedef struct packed {
    logic [7:0] p0;
    logic [7:0] p1;
    logic [7:0] p2;
    logic [7:0] p3;
  } port_pins_t;

  // Request presented to the memory array
  typedef struct packed {
    logic [15:0] addr;
    logic [7:0] wdata;
    logic wr;
    logic enc_wr;
    logic [2:0] lock_wr;
  } mem_req_t;
endpackage

// [design/sync2.sv]
// Two flip-flop synchroniser for a bundle of pin levels
`timescale 1ns/10ps
module sync2 #(
  parameter int W = 1
) (
  input wire logic i_mclk, // Clock
  input wire logic i_rst, // Synchronous reset
  input wire logic i_ce, // Clock enable
  input wire logic [W-1:0] i_d, // Asynchronous level
  output logic [W-1:0] o_q // Synchronised level
);
  logic [W-1:0] meta_q;
  logic [W-1:0] meta_d;
  logic [W-1:0] sync_q;
  logic [W-1:0] sync_d;

  // First stage is read only by the second
  always_comb begin
    meta_d = meta_q;
    sync_d = sync_q;
    if (i_ce) begin
      meta_d = i_d;
      sync_d = meta_q;
    end
  end

  always_ff @(posedge i_mclk) begin
    if (i_rst) begin
      meta_q <= '0;
      sync_q <= '0;
    end else begin
      meta_q <= meta_d;
      sync_q <= sync_d;
    end
  end

  assign o_q = sync_q;
endmodule

// [design/prog_mode_ctrl.sv]
// Emulation entry and programming set-up mode decoder
`timescale 1ns/10ps
`include "prog_cfg.svh"
// How it works
// R1 - Emulator pulls latch strobe low during reset
// R2 - Strobe held low through release enters emulation
// R3 - Emulation floats port 0, pulls others weakly
// R4 - Plain reset without sequence leaves emulation
// R5 - Address from port 1, 2 and 3 pins
// R6 - Data bits exchanged on port 0 in order
// R7 - Programmer pulses strobe, applies high voltage
// R8 - Code and encryption program pin codes
// R9 - Lock bit pin codes with P2.6 high
// R10 - Verify and signature read pin codes
// R11 - Four fixed identification bytes held
// R12 - Set high security only after verification; lock writes are accepted whether or not a verify came first
module prog_mode_ctrl #(
  parameter int ADDR_BITS = `ADDR_W
) (
  input wire logic i_mclk, // Clock
  input wire logic i_rst, // Synchronous reset, active high
  input wire logic i_ce, // Clock enable
  input wire logic i_rst_pin, // Reset pin level
  input wire logic i_program_store_strobe, // Program store strobe pin in
  input wire logic i_latch_or_write_pulse_pin, // Latch strobe / write pulse pin in
  input wire logic i_external_access_or_high_voltage_pin, // High voltage present flag
  input wire prog_pkg::port_pins_t i_ports, // Port pin inputs
  input wire logic [`DATA_W-1:0] i_mem_rdata, // Code byte from the array
  output prog_pkg::port_pins_t o_ports, // Port pin outputs
  output prog_pkg::port_pins_t o_ports_oe, // Port pin strong drive enables
  output logic [3:0] o_port_weak_pu, // Weak pull-up per port 0..3
  output logic o_strobes_weak_pu, // Weak pull-up on both strobes
  output logic o_osc_run, // Oscillator enable
  output logic o_emulation, // Emulation mode active
  output prog_pkg::op_t o_op, // Decoded set-up mode
  output prog_pkg::mem_req_t o_mem_req, // Array request
  output logic [`LOCK_W-1:0] o_lock_bits // Lock bits programmed so far
);
  // Four ports plus four single pins share one synchroniser so they stay aligned
  localparam int NSYNC = 4 * `DATA_W + 4;
  logic [NSYNC-1:0] raw;
  logic [NSYNC-1:0] syn;
  prog_pkg::port_pins_t pins;
  logic rst_s, ps_s, ale_s, vpp_s;

  assign raw = {i_rst_pin, i_program_store_strobe, i_latch_or_write_pulse_pin,
                i_external_access_or_high_voltage_pin, i_ports};

  sync2 #(.W(NSYNC)) u_sync (
    .i_mclk(i_mclk),
    .i_rst(i_rst),
    .i_ce(i_ce),
    .i_d(raw),
    .o_q(syn)
  );

  // Unpack in the order packed above
  assign {rst_s, ps_s, ale_s, vpp_s, pins} = syn;

  // Emulation entry state; reset pin is seen after synchronising
  logic rst_s_q, rst_s_d;
  logic armed_q, armed_d;
  logic emu_q, emu_d;
  logic ale_q, ale_d;

  always_comb begin
    rst_s_d = rst_s_q;
    armed_d = armed_q;
    emu_d = emu_q;
    ale_d = ale_q;
    if (i_ce) begin
      rst_s_d = rst_s;
      ale_d = ale_s;
      if (rst_s) begin
        // Re-armed every reset cycle; the last value before release decides
        armed_d = !ale_s && ps_s; // R1
        if (!rst_s_q) begin
          emu_d = 1'b0; // R4
        end
      end else if (rst_s_q) begin
        // Release edge: strobe must still be low to enter
        emu_d = armed_q && !ale_s; // R2
        armed_d = 1'b0;
      end
    end
  end

  always_ff @(posedge i_mclk) begin
    if (i_rst) begin
      rst_s_q <= 1'b0;
      armed_q <= 1'b0;
      emu_q <= 1'b0;
      // Matches the synchroniser's reset level so no false strobe edge follows reset
      ale_q <= 1'b0;
    end else begin
      rst_s_q <= rst_s_d;
      armed_q <= armed_d;
      emu_q <= emu_d;
      ale_q <= ale_d;
    end
  end

  // Set-up mode decode from static control pins
  logic [4:0] sel;
  logic in_setup;
  prog_pkg::op_t op;

  assign sel = {pins.p2[6], pins.p2[7], pins.p3[3], pins.p3[6], pins.p3[7]};
  // Held off while emulating so the emulator alone owns the pins
  assign in_setup = rst_s && !ps_s && !emu_q;

  always_comb begin
    op = prog_pkg::OP_IDLE;
    if (in_setup) begin
      if (sel == `SEL_PROG_CODE) begin
        op = prog_pkg::OP_PROG_CODE; // R8
      end else if (sel == `SEL_PROG_ENC) begin
        op = prog_pkg::OP_PROG_ENC; // R8
      end else if (sel == `SEL_LOCK1) begin
        op = prog_pkg::OP_LOCK1; // R9
      end else if (sel == `SEL_LOCK2) begin
        op = prog_pkg::OP_LOCK2; // R9
      end else if (sel == `SEL_LOCK3) begin
        op = prog_pkg::OP_LOCK3; // R9
      end else if ((sel & `SEL_MASK_READ) == `SEL_VERIFY) begin
        op = prog_pkg::OP_VERIFY; // R10
      end else if ((sel & `SEL_MASK_READ) == `SEL_SIG) begin
        op = prog_pkg::OP_SIG_READ; // R10
      end
    end
  end

  // Address bits above the variant size read as zero
  logic [`ADDR_W-1:0] addr_full, addr;
  assign addr_full = {pins.p3[5], pins.p3[4], pins.p2[5:0], pins.p1}; // R5
  // Mask is formed one bit wider so a full-width shift does not wrap
  assign addr = addr_full & `ADDR_W'((17'h1 << ADDR_BITS) - 17'h1);

  // Write pulse: falling edge of strobe with high voltage applied
  logic wr_edge, is_prog;
  assign wr_edge = ale_q && !ale_s; // R7
  assign is_prog = vpp_s && (op == prog_pkg::OP_PROG_CODE || op == prog_pkg::OP_PROG_ENC ||
                   op == prog_pkg::OP_LOCK1 || op == prog_pkg::OP_LOCK2 || op == prog_pkg::OP_LOCK3);

  // Signature table is fixed; values here are arbitrary
  logic [`DATA_W-1:0] sig_rom [`SIG_COUNT];
  assign sig_rom[0] = `SIG_BYTE0; // R11
  assign sig_rom[1] = `SIG_BYTE1;
  assign sig_rom[2] = `SIG_BYTE2;
  assign sig_rom[3] = `SIG_BYTE3;

  // Registered outputs
  prog_pkg::mem_req_t req_q, req_d;
  logic [`DATA_W-1:0] rdata_q, rdata_d;
  logic rd_oe_q, rd_oe_d;
  logic [`LOCK_W-1:0] lock_q, lock_d;
  prog_pkg::op_t op_q, op_d;

  always_comb begin
    req_d = req_q;
    rdata_d = rdata_q;
    rd_oe_d = rd_oe_q;
    lock_d = lock_q;
    op_d = op_q;
    if (i_ce) begin
      op_d = op;
      req_d.addr = addr;
      req_d.wdata = pins.p0; // R6
      req_d.wr = wr_edge && is_prog && op == prog_pkg::OP_PROG_CODE;
      req_d.enc_wr = wr_edge && is_prog && op == prog_pkg::OP_PROG_ENC && addr <= `ENC_LAST_ADDR;
      req_d.lock_wr = '0;
      // Lock bits only ever set; order is the programmer's concern
      if (wr_edge && is_prog) begin
        if (op == prog_pkg::OP_LOCK1) req_d.lock_wr[0] = 1'b1; // R9
        if (op == prog_pkg::OP_LOCK2) req_d.lock_wr[1] = 1'b1; // R9
        if (op == prog_pkg::OP_LOCK3) req_d.lock_wr[2] = 1'b1; // R9
      end
      lock_d = lock_q | req_d.lock_wr;
      // Read data is driven only while the strobe pin is high
      rd_oe_d = (op == prog_pkg::OP_VERIFY || op == prog_pkg::OP_SIG_READ) && ale_s;
      rdata_d = (op == prog_pkg::OP_SIG_READ) ? sig_rom[addr[`SIG_IDX_W-1:0]] : i_mem_rdata; // R10
    end
  end

  always_ff @(posedge i_mclk) begin
    if (i_rst) begin
      req_q <= '0;
      rdata_q <= '0;
      rd_oe_q <= 1'b0;
      lock_q <= '0;
      op_q <= prog_pkg::OP_IDLE;
    end else begin
      req_q <= req_d;
      rdata_q <= rdata_d;
      rd_oe_q <= rd_oe_d;
      lock_q <= lock_d;
      op_q <= op_d;
    end
  end

  // Pin drive: in emulation nothing is driven strongly
  always_comb begin
    o_ports = '0;
    o_ports_oe = '0;
    o_ports.p0 = rdata_q; // R6
    o_ports_oe.p0 = {`DATA_W{rd_oe_q && !emu_q}}; // R3
  end

  // Ports 1 to 3 keep a weak pull-up in emulation; port 0 floats
  always_comb begin
    o_port_weak_pu = '0;
    if (emu_q) begin
      o_port_weak_pu = `PU_EMU_MASK; // R3
    end
  end

  // Strobes share the pull-up; the oscillator never stops
  assign o_strobes_weak_pu = emu_q; // R3
  assign o_osc_run = 1'b1; // R3
  // Status outputs come straight from their registers
  assign o_emulation = emu_q;
  assign o_op = op_q;
  assign o_mem_req = req_q;
  assign o_lock_bits = lock_q;
endmodule

// [tb/prog_host.sv]
// Programmer model that spreads set-up codes over the port pins
`timescale 1ns/10ps
module prog_host (
  input wire logic [4:0] i_sel, // Set-up code
  input wire logic [15:0] i_addr, // Array address
  input wire logic [7:0] i_wdata, // Byte sent on port 0
  output prog_pkg::port_pins_t o_pins // Pin levels
);
  // Data bits go on port 0 in order; control bits beside the address
  always_comb begin
    o_pins.p0 = i_wdata;
    o_pins.p1 = i_addr[7:0];
    o_pins.p2 = {i_sel[3], i_sel[4], i_addr[13:8]};
    o_pins.p3 = {i_sel[0], i_sel[1], i_addr[15:14], i_sel[2], 3'h0};
  end
endmodule

// [tb/prog_mode_ctrl_checker.sv]
// Concurrent checks on the decoder outputs
`timescale 1ns/10ps
module prog_mode_ctrl_checker (
  input wire logic i_mclk, // Clock
  input wire logic i_rst, // Reset
  input wire logic i_rst_pin, // Reset pin
  input wire logic [3:0] o_port_weak_pu, // Port pull-ups
  input wire logic o_strobes_weak_pu, // Strobe pull-ups
  input wire logic o_osc_run, // Oscillator
  input wire logic o_emulation, // Emulation
  input wire prog_pkg::port_pins_t o_ports_oe, // Drive enables
  input wire prog_pkg::op_t o_op, // Mode
  input wire prog_pkg::mem_req_t o_mem_req, // Request
  input wire logic [2:0] o_lock_bits // Lock bits
);
  default clocking @(posedge i_mclk); endclocking
  default disable iff (i_rst);
  // Pin states while emulating
  a_emu_pull_up: assert property (o_emulation |-> o_port_weak_pu == 4'he && o_strobes_weak_pu) else $error("pull");
  a_emu_float: assert property (o_emulation |-> o_ports_oe.p0 == 8'h00) else $error("float");
  a_osc_on: assert property (o_osc_run) else $error("osc");
  // Reset pin quiet keeps the mode, a long reset ends it
  a_emu_stays: assert property ((!i_rst_pin[*5] ##0 o_emulation) |=> o_emulation) else $error("stay");
  a_emu_leaves: assert property (i_rst_pin[*5] |-> !o_emulation) else $error("leave");
  // Writes are single pulses tied to the decoded mode
  a_wr_pulse: assert property (o_mem_req.wr |=> !o_mem_req.wr) else $error("pulse");
  a_wr_mode: assert property (o_mem_req.wr |-> o_op == prog_pkg::OP_PROG_CODE) else $error("wr mode");
  a_enc_range: assert property (o_mem_req.enc_wr |-> o_op == prog_pkg::OP_PROG_ENC
    && o_mem_req.addr <= 16'h003f) else $error("enc");
  a_lock_mode: assert property (o_mem_req.lock_wr != 3'h0 |-> o_op >= prog_pkg::OP_LOCK1) else $error("lock");
  a_lock_sticky: assert property ((o_lock_bits & $past(o_lock_bits)) == $past(o_lock_bits)) else $error("sticky");
  a_read_drive: assert property (o_ports_oe.p0 != 8'h00 |->
    o_op inside {prog_pkg::OP_VERIFY, prog_pkg::OP_SIG_READ}) else $error("drive");
  c_emu: cover property (o_emulation);
  c_wr: cover property (o_mem_req.wr);
  c_lock: cover property (o_lock_bits == 3'h7);
endmodule

// [tb/prog_mode_ctrl_test.sv]
// Self-checking bench for the set-up decoder
`timescale 1ns/10ps
`include "prog_cfg.svh"
module prog_mode_ctrl_test;
  logic i_mclk = 1'b0;
  logic i_rst = 1'b1;
  logic rpin = 1'b0, pss = 1'b1, lstb = 1'b1, hv = 1'b0, ce = 1'b1;
  logic [4:0] sel = 5'h00;
  logic [15:0] addr = 16'h0000;
  logic [7:0] wd = 8'h00, rdata = 8'h00;
  logic [7:0] sig [4] = '{`SIG_BYTE0, `SIG_BYTE1, `SIG_BYTE2, `SIG_BYTE3};
  int error_cnt = 0, n_checks = 0;
  prog_pkg::port_pins_t pins, o_ports, o_oe;
  logic [3:0] o_pu;
  logic o_spu, o_osc, o_emu;
  prog_pkg::op_t o_op;
  prog_pkg::mem_req_t o_req, got;
  logic [2:0] o_lock;
  // Free-running 50 MHz clock
  always #10 i_mclk = ~i_mclk;
  prog_host HOST (.i_sel(sel), .i_addr(addr), .i_wdata(wd), .o_pins(pins));
  prog_mode_ctrl DUT (.i_mclk(i_mclk), .i_rst(i_rst), .i_ce(ce), .i_rst_pin(rpin),
    .i_program_store_strobe(pss), .i_latch_or_write_pulse_pin(lstb),
    .i_external_access_or_high_voltage_pin(hv), .i_ports(pins), .i_mem_rdata(rdata),
    .o_ports(o_ports), .o_ports_oe(o_oe), .o_port_weak_pu(o_pu), .o_strobes_weak_pu(o_spu),
    .o_osc_run(o_osc), .o_emulation(o_emu), .o_op(o_op), .o_mem_req(o_req), .o_lock_bits(o_lock));
  task automatic chk(input string nm, input logic [15:0] exp, input logic [15:0] seen);
    n_checks++;
    if (seen !== exp) begin
      error_cnt++;
      $display("[ERR] %s expected %h seen %h", nm, exp, seen);
    end
  endtask
  // Sample 1 ns past the edge so registered outputs have landed
  task automatic step(input int n);
    repeat (n) @(posedge i_mclk);
    #1;
  endtask
  task automatic setup(input logic [4:0] s, input logic v, input logic [15:0] a, input logic [7:0] d);
    @(posedge i_mclk);
    sel <= s;
    hv <= v;
    addr <= a;
    wd <= d;
    step(4);
  endtask
  // Strobe falls, then any request pulse is caught in its one cycle
  task automatic pulse();
    got = '0;
    @(posedge i_mclk) lstb <= 1'b0;
    for (int i = 0; i < 6; i++) begin
      step(1);
      if (o_req.wr === 1'b1 || o_req.enc_wr === 1'b1 || o_req.lock_wr !== 3'h0) got = o_req;
    end
    @(posedge i_mclk) lstb <= 1'b1;
    step(4);
  endtask
  task automatic t_emu();
    @(posedge i_mclk) {rpin, pss, lstb} <= 3'b110;
    step(4);
    @(posedge i_mclk) rpin <= 1'b0;
    step(5);
    chk("emu", 1, o_emu);
    chk("pu", 16'h1e, {o_spu, o_pu});
    chk("oe", 0, o_oe.p0);
    chk("oe123", 0, {15'h0000, |o_oe[23:0]});
    chk("osc", 1, o_osc);
    @(posedge i_mclk) {rpin, lstb} <= 2'b11;
    step(5);
    @(posedge i_mclk) rpin <= 1'b0;
    step(5);
    chk("emu off", 0, o_emu);
    $display("emu done");
  endtask
  task automatic t_prog();
    @(posedge i_mclk) {rpin, pss} <= 2'b10;
    setup(5'h0f, 1'b1, 16'hc2a5, 8'h96);
    pulse();
    chk("wr", 1, got.wr);
    chk("addr", 16'hc2a5, got.addr);
    chk("wdata", 8'h96, got.wdata);
    setup(5'h0f, 1'b0, 16'h0001, 8'h55);
    pulse();
    chk("wr lowv", 0, got.wr);
    setup(5'h0d, 1'b1, 16'h003f, 8'h11);
    pulse();
    chk("enc", 1, got.enc_wr);
    setup(5'h0d, 1'b1, 16'h0040, 8'h11);
    pulse();
    chk("enc out", 0, got.enc_wr);
    $display("prog done");
  endtask
  task automatic t_read();
    @(posedge i_mclk) rdata <= 8'h6b;
    setup(5'h03, 1'b0, 16'h0010, 8'h94);
    chk("vop", prog_pkg::OP_VERIFY, o_op);
    chk("vdata", 8'h6b, o_ports.p0);
    chk("voe", 8'hff, o_oe.p0);
    setup(5'h0b, 1'b0, 16'h0011, 8'h00);
    chk("vop p27", prog_pkg::OP_VERIFY, o_op);
    for (int i = 0; i < 4; i++) begin
      setup(5'h00, 1'b0, 16'(i), ~sig[i]);
      chk("sig", sig[i], o_ports.p0);
    end
    $display("read done");
  endtask
  task automatic t_lock();
    logic [4:0] lk [3] = '{5'h1f, 5'h1c, 5'h16};
    for (int i = 0; i < 3; i++) begin
      setup(lk[i], 1'b1, 16'h0000, 8'h00);
      pulse();
      chk("lock_wr", 3'h1 << i, got.lock_wr);
      chk("lock", (4'h2 << i) - 4'h1, o_lock);
    end
    $display("lock done");
  endtask
  // Enable low freezes everything, pins included, until it returns
  task automatic t_freeze();
    @(posedge i_mclk) ce <= 1'b0;
    setup(5'h0f, 1'b1, 16'h0002, 8'h77);
    pulse();
    chk("frz wr", 0, got.wr);
    chk("frz op", prog_pkg::OP_LOCK3, o_op);
    @(posedge i_mclk) ce <= 1'b1;
    step(4);
    chk("run op", prog_pkg::OP_PROG_CODE, o_op);
    $display("freeze done");
  endtask
  task automatic complete_run();
    $display("checks %0d errors %0d", n_checks, error_cnt);
    if (error_cnt == 0 && n_checks > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask
  initial begin
    repeat (6) @(posedge i_mclk);
    i_rst <= 1'b0;
    t_emu();
    t_prog();
    t_read();
    t_lock();
    t_freeze();
    complete_run();
  end
  // Whole run is a few hundred cycles
  initial begin
    #200000;
    error_cnt++;
    complete_run();
  end
endmodule
bind prog_mode_ctrl prog_mode_ctrl_checker CHK (.i_mclk(i_mclk), .i_rst(i_rst), .i_rst_pin(i_rst_pin),
  .o_port_weak_pu(o_port_weak_pu), .o_strobes_weak_pu(o_strobes_weak_pu), .o_osc_run(o_osc_run),
  .o_emulation(o_emulation), .o_ports_oe(o_ports_oe), .o_op(o_op), .o_mem_req(o_mem_req),
  .o_lock_bits(o_lock_bits));
